// ===== hw/startup_defs.svh
// startup_defs.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name; definitions only
`ifndef STARTUP_DEFS_SVH
`define STARTUP_DEFS_SVH

// register byte offsets
`define OFF_STATUS      12'h000
`define OFF_MASK        12'h004
`define OFF_CONFIG      12'h008
`define OFF_START       12'h00C
`define OFF_RESTART     12'h010
`define OFF_RTC_DIV     12'h014

// status / mask bit positions
`define EV_NMI          0
`define EV_HALT         1
`define EV_RTC          2
`define EV_WIDTH        3

// config bit positions
`define CFG_NMI_EN      0
`define CFG_IAK_BLOCK   1
`define CFG_BRK_HALT    2
`define CFG_HALT_IRQ    3
`define CFG_RTC_SEL_LO  4
`define CFG_RTC_SEL_HI  5
`define CFG_WIDTH       6
// default: nmi enabled, iak blocks, break drives halt, halt irq, 60 Hz
`define CFG_RESET       6'h1F

`define MASK_RESET      3'h0
`define RESTART_STEP    16'h0004
`define HALT_PRIORITY   3'h7
`define HALT_VECTOR     9'h060

// timing: wake delay one second, rtc periods
`define CLK_HZ          100000000
`define WAKE_TIME_MS    1000
`define WAKE_CYCLES     (`CLK_HZ / 1000 * `WAKE_TIME_MS)
`define RTC50_CYCLES    (`CLK_HZ / 50)
`define RTC60_CYCLES    (`CLK_HZ / 60)
`define RTC800_CYCLES   (`CLK_HZ / 800)

`endif

// ===== hw/startup_pkg.sv
// startup_pkg: types shared by the startup block
// assumes startup_defs.svh is on the include path
package startup_pkg;
  typedef logic [15:0] word_t;
  typedef logic [2:0]  strap_t;
  typedef enum logic [1:0] {RTC_50, RTC_60, RTC_800, RTC_OFF} rtc_sel_t;
  typedef enum {WAKE_HOLD, WAKE_DONE} wake_state_t;
endpackage : startup_pkg

// ===== hw/edge_if.sv
// edge_if: carries event inputs into the edge detector and pulses back
// assumes one clock domain, pclk
`timescale 1ns/1ps
interface edge_if;
  logic [2:0] level;
  logic [2:0] rise;
  modport det  (input level, output rise);
  modport user (output level, input rise);
endinterface : edge_if

// ===== hw/edge_detect.sv
// edge_detect: rising edge pulses for three synchronous event levels
// assumes inputs are already synchronous to pclk
`timescale 1ns/1ps
module edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  edge_if.det       ev
);
  logic [2:0] prev_r;
  logic [2:0] prev_nxt;

  // previous level for the edge compare
  always_comb begin
    prev_nxt = ev.level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 3'h0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // a held level fires once only
  assign ev.rise = ev.level & ~prev_r;
endmodule : edge_detect

// ===== hw/startup_config.sv
// startup_config: start/restart address straps, wake-up delay, event routing
// assumes straps and bus lines are synchronous to pclk; apb master drives regs
// Operation
// - start address presented as first fetch
// - three straps pick one of eight addresses
// - restart address is start plus four
// - power-ok held negated one second
// - disable strap bypasses the wake delay
// - timeout nmi request edge triggered, gated
// - halt request level seven, edge triggered
// - bus timeout raises nmi except acknowledge
// - serial break drives halt, vector 140
// - config bits 5:4 select 50/60/800 Hz event
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "startup_defs.svh"
module startup_config #(
  parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire startup_pkg::strap_t start_strap,
  input  wire logic                wake_disable,
  input  wire logic                backplane_power_ok,
  input  wire logic                bus_timeout_error,
  input  wire logic                interrupt_acknowledge_cycle,
  input  wire logic                serial_line_unit_break,
  input  wire logic                bus_halt_line_in,
  output startup_pkg::word_t       start_address,
  output startup_pkg::word_t       restart_address,
  output logic                     start_valid,
  output logic                     bus_power_ok,
  output logic                     timeout_nmi_request,
  output logic                     halt_irq_request,
  output logic [2:0]               halt_irq_priority,
  output logic [8:0]               halt_irq_vector,
  output logic                     bus_halt_line,
  output logic                     bus_event_line,
  output logic                     irq
);
  import startup_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // strap decode

  // eight strap codes to octal start addresses
  function automatic word_t decode_start(input strap_t s);
    case (s)
      3'h5:    decode_start = 16'h0000; // 000000
      3'h4:    decode_start = 16'h1000; // 010000
      3'h3:    decode_start = 16'h2000; // 020000
      3'h2:    decode_start = 16'h4000; // 040000
      3'h1:    decode_start = 16'h8000; // 100000
      3'h0:    decode_start = 16'hC000; // 140000
      3'h7:    decode_start = 16'hF400; // 172000
      default: decode_start = 16'hF600; // 173000
    endcase
  endfunction : decode_start

  // strap capture: in reset the address regs clear, first edge after takes straps
  logic  captured_r;
  logic  captured_nxt;
  word_t start_r;
  word_t start_nxt;
  word_t restart_r;
  word_t restart_nxt;

  always_comb begin
    captured_nxt = 1'b1;
    start_nxt    = start_r;
    restart_nxt  = restart_r;
    if (!captured_r) begin
      start_nxt   = decode_start(start_strap);
      restart_nxt = decode_start(start_strap) + `RESTART_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_r <= 1'b0;
      start_r    <= 16'h0000;
      restart_r  <= 16'h0000;
    end else begin
      captured_r <= captured_nxt;
      start_r    <= start_nxt;
      restart_r  <= restart_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-up delay

  logic [31:0] wake_cnt_r;
  logic [31:0] wake_cnt_nxt;
  wake_state_t wake_r;
  wake_state_t wake_nxt;
  logic        pok_r;
  logic        pok_nxt;

  // counter holds power-ok negated; the strap passes the backplane signal through
  always_comb begin
    wake_nxt     = wake_r;
    wake_cnt_nxt = wake_cnt_r;
    case (wake_r)
      WAKE_HOLD: begin
        if (wake_cnt_r >= WAKE_CYCLES - 1) begin
          wake_nxt = WAKE_DONE;
        end else begin
          wake_cnt_nxt = wake_cnt_r + 32'h1;
        end
      end
      WAKE_DONE: wake_cnt_nxt = wake_cnt_r;
      default:   wake_nxt = WAKE_HOLD;
    endcase
    if (wake_disable) begin
      pok_nxt = backplane_power_ok;
    end else begin
      pok_nxt = (wake_r == WAKE_DONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r     <= WAKE_HOLD;
      wake_cnt_r <= 32'h0;
      pok_r      <= 1'b0;
    end else begin
      wake_r     <= wake_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      pok_r      <= pok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // real-time clock dividers

  logic [20:0] div50_r, div50_nxt;
  logic [20:0] div60_r, div60_nxt;
  logic [16:0] div800_r, div800_nxt;
  logic [2:0]  rtc_r, rtc_nxt;       // 800, 60, 50 Hz square waves

  // each divider toggles its square wave at half period
  always_comb begin
    div50_nxt  = div50_r + 21'h1;
    div60_nxt  = div60_r + 21'h1;
    div800_nxt = div800_r + 17'h1;
    rtc_nxt    = rtc_r;
    if (div50_r == 21'((`RTC50_CYCLES / 2) - 1)) begin
      div50_nxt  = 21'h0;
      rtc_nxt[0] = ~rtc_r[0];
    end
    if (div60_r == 21'((`RTC60_CYCLES / 2) - 1)) begin
      div60_nxt  = 21'h0;
      rtc_nxt[1] = ~rtc_r[1];
    end
    if (div800_r == 17'((`RTC800_CYCLES / 2) - 1)) begin
      div800_nxt = 17'h0;
      rtc_nxt[2] = ~rtc_r[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div50_r  <= 21'h0;
      div60_r  <= 21'h0;
      div800_r <= 17'h0;
      rtc_r    <= 3'h0;
    end else begin
      div50_r  <= div50_nxt;
      div60_r  <= div60_nxt;
      div800_r <= div800_nxt;
      rtc_r    <= rtc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event routing

  logic [`CFG_WIDTH-1:0] cfg_r;
  logic                  halt_out_r, halt_out_nxt;
  logic                  evt_r, evt_nxt;
  rtc_sel_t              rtc_sel;
  edge_if                edges ();

  assign rtc_sel = rtc_sel_t'(cfg_r[`CFG_RTC_SEL_HI:`CFG_RTC_SEL_LO]);

  // break drives the halt line only when so configured
  always_comb begin
    halt_out_nxt = cfg_r[`CFG_BRK_HALT] & serial_line_unit_break;
    case (rtc_sel)
      RTC_50:  evt_nxt = rtc_r[0];
      RTC_60:  evt_nxt = rtc_r[1];
      RTC_800: evt_nxt = rtc_r[2];
      default: evt_nxt = 1'b0;
    endcase
  end

  // edge inputs: timeout (blocked in acknowledge), received halt, event line
  // acknowledge timeouts excluded
  assign edges.level[`EV_NMI]  = bus_timeout_error
                                 & ~(cfg_r[`CFG_IAK_BLOCK] & interrupt_acknowledge_cycle);
  assign edges.level[`EV_HALT] = bus_halt_line_in;
  assign edges.level[`EV_RTC]  = evt_r;

  edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .ev      (edges.det)
  );

  logic nmi_r, nmi_nxt;
  logic hreq_r, hreq_nxt;

  // one-cycle request pulses from edges, gated by enables
  always_comb begin
    nmi_nxt  = edges.rise[`EV_NMI] & cfg_r[`CFG_NMI_EN];
    hreq_nxt = edges.rise[`EV_HALT] & cfg_r[`CFG_HALT_IRQ];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_out_r <= 1'b0;
      evt_r      <= 1'b0;
      nmi_r      <= 1'b0;
      hreq_r     <= 1'b0;
    end else begin
      halt_out_r <= halt_out_nxt;
      evt_r      <= evt_nxt;
      nmi_r      <= nmi_nxt;
      hreq_r     <= hreq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb registers and interrupt

  logic [`EV_WIDTH-1:0]  stat_r, stat_nxt;
  logic [`EV_WIDTH-1:0]  mask_r, mask_nxt;
  logic [`CFG_WIDTH-1:0] cfg_nxt;
  logic [31:0]           rdata_nxt;
  logic                  ready_nxt, err_nxt, irq_nxt;
  logic                  setup, wr;
  logic [`EV_WIDTH-1:0]  ev_set;

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite & pready;
  assign ev_set = {edges.rise[`EV_RTC], hreq_nxt, nmi_nxt};

  // no wait state: ready rises in access cycle; set beats write-one-clear
  always_comb begin
    stat_nxt  = stat_r;
    mask_nxt  = mask_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = prdata;
    ready_nxt = setup;
    err_nxt   = 1'b0;
    if (setup) begin
      case (paddr)
        `OFF_STATUS:  rdata_nxt = {29'h0, stat_r};
        `OFF_MASK:    rdata_nxt = {29'h0, mask_r};
        `OFF_CONFIG:  rdata_nxt = {26'h0, cfg_r};
        `OFF_START:   rdata_nxt = {16'h0, start_r};
        `OFF_RESTART: rdata_nxt = {16'h0, restart_r};
        `OFF_RTC_DIV: rdata_nxt = {29'h0, rtc_r};
        default: begin
          rdata_nxt = 32'h0;
          err_nxt   = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        `OFF_STATUS: stat_nxt = stat_r & ~pwdata[`EV_WIDTH-1:0];
        `OFF_MASK:   mask_nxt = pwdata[`EV_WIDTH-1:0];
        `OFF_CONFIG: cfg_nxt  = pwdata[`CFG_WIDTH-1:0];
        default:     cfg_nxt  = cfg_r;
      endcase
    end
    stat_nxt = stat_nxt | ev_set;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r  <= 3'h0;
      mask_r  <= `MASK_RESET;
      cfg_r   <= `CFG_RESET;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      cfg_r   <= cfg_nxt;
      prdata  <= rdata_nxt;
      pready  <= ready_nxt;
      pslverr <= err_nxt;
      irq     <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops, except the constant halt priority and vector
  // start address to program counter load
  assign start_address       = start_r;
  assign restart_address     = restart_r;
  assign start_valid         = captured_r;
  assign bus_power_ok        = pok_r;
  assign timeout_nmi_request = nmi_r;
  assign halt_irq_request    = hreq_r;
  assign halt_irq_priority   = `HALT_PRIORITY;
  assign halt_irq_vector     = `HALT_VECTOR;
  assign bus_halt_line       = halt_out_r;
  assign bus_event_line      = evt_r;
endmodule : startup_config

// ===== tb/startup_config_chk.sv
// startup_config_chk: port assertions for the startup block
// assumes config bits 3:0 keep their reset routing during the run
`timescale 1ns/1ps
module startup_config_chk
  import startup_pkg::*;
#(parameter int unsigned WAKE_CYCLES = 20) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire startup_pkg::strap_t start_strap,
  input wire logic                wake_disable,
  input wire logic                backplane_power_ok,
  input wire logic                bus_timeout_error,
  input wire logic                interrupt_acknowledge_cycle,
  input wire logic                serial_line_unit_break,
  input wire logic                bus_halt_line_in,
  input wire startup_pkg::word_t  start_address,
  input wire startup_pkg::word_t  restart_address,
  input wire logic                start_valid,
  input wire logic                bus_power_ok,
  input wire logic                timeout_nmi_request,
  input wire logic                halt_irq_request,
  input wire logic                bus_halt_line
);
  localparam word_t START_MAP [8] = '{16'hC000, 16'h8000, 16'h4000, 16'h2000,
    16'h1000, 16'h0000, 16'hF600, 16'hF400};
  int unsigned up_cnt_r;
  int unsigned up_cnt_nxt;
  ////////////////////////////////////////
  // cycles since release, saturating so it never wraps
  always_comb up_cnt_nxt = (up_cnt_r > WAKE_CYCLES) ? up_cnt_r : up_cnt_r + 1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up_cnt_r <= 0;
    else up_cnt_r <= up_cnt_nxt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tmo_rise; $rose(bus_timeout_error); endsequence
  chk_start_map: assert property ($rose(start_valid) |->
    start_address == START_MAP[$past(start_strap)]) else $error("start map");
  chk_restart_sum: assert property (start_valid |->
    restart_address == start_address + 16'h0004) else $error("restart sum");
  chk_wake_low: assert property (!wake_disable && up_cnt_r <= WAKE_CYCLES |->
    !bus_power_ok) else $error("power ok early");
  chk_follow_bp: assert property (wake_disable && up_cnt_r > 1 |->
    bus_power_ok == $past(backplane_power_ok)) else $error("power ok bypass");
  chk_nmi_edge: assert property (s_tmo_rise ##0 !interrupt_acknowledge_cycle |=>
    timeout_nmi_request) else $error("nmi missing");
  chk_nmi_iak: assert property (s_tmo_rise ##0 interrupt_acknowledge_cycle |=>
    !timeout_nmi_request) else $error("nmi in ack");
  chk_halt_irq: assert property ($rose(bus_halt_line_in) |=>
    halt_irq_request) else $error("halt irq missing");
  chk_break_halt: assert property ($past(presetn) |->
    bus_halt_line == $past(serial_line_unit_break)) else $error("halt line");
endmodule : startup_config_chk
bind startup_config startup_config_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (.pclk, .presetn,
  .start_strap, .wake_disable, .backplane_power_ok, .bus_timeout_error,
  .interrupt_acknowledge_cycle, .serial_line_unit_break, .bus_halt_line_in, .start_address,
  .restart_address, .start_valid, .bus_power_ok, .timeout_nmi_request, .halt_irq_request,
  .bus_halt_line);

// ===== tb/bus_partner.sv
// bus_partner: processor core and backplane facing the startup block
// assumes its tasks are called just after a rising pclk edge
`timescale 1ns/1ps
module bus_partner (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire startup_pkg::word_t start_address,
  input  wire logic               start_valid,
  input  wire logic               timeout_nmi_request,
  input  wire logic               halt_irq_request,
  input  wire logic               bus_halt_line,
  output logic                    backplane_power_ok,
  output logic                    bus_timeout_error,
  output logic                    interrupt_acknowledge_cycle,
  output logic                    bus_halt_line_in,
  output startup_pkg::word_t      fetch_pc,
  output int                      nmi_cnt,
  output int                      halt_cnt
);
  import startup_pkg::*;
  logic halt_drv;
  logic loaded_r;
  assign bus_halt_line_in = halt_drv | bus_halt_line;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= 1'b0;
      fetch_pc <= '0;
      nmi_cnt <= 0;
      halt_cnt <= 0;
    end else begin
      if (start_valid && !loaded_r) fetch_pc <= start_address;
      loaded_r <= start_valid;
      nmi_cnt <= nmi_cnt + int'(timeout_nmi_request);
      halt_cnt <= halt_cnt + int'(halt_irq_request);
    end
  end
  // one fault or halt; hold sets a prompt or a slow release
  task automatic pulse(input bit halt, input logic ack, input int hold);
    interrupt_acknowledge_cycle <= ack;
    if (halt) halt_drv <= 1'b1;
    else bus_timeout_error <= 1'b1;
    repeat (hold) @(posedge pclk);
    halt_drv <= 1'b0;
    bus_timeout_error <= 1'b0;
    interrupt_acknowledge_cycle <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic power(input logic v);
    backplane_power_ok <= v;
  endtask : power
  initial begin
    halt_drv = 1'b0;
    bus_timeout_error = 1'b0;
    interrupt_acknowledge_cycle = 1'b0;
    backplane_power_ok = 1'b0;
  end
endmodule : bus_partner

// ===== tb/test_startup_config.sv
// test_startup_config: apb and port tests of straps, wake-up, events
// assumes bus_partner plays the processor and the backplane
`timescale 1ns/1ps
`include "startup_defs.svh"
module test_startup_config;
  import startup_pkg::*;
  localparam int unsigned WAKE = 20;
  localparam word_t START_MAP [8] = '{16'hC000, 16'h8000, 16'h4000, 16'h2000,
    16'h1000, 16'h0000, 16'hF600, 16'hF400};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  strap_t      start_strap;
  word_t       start_address, restart_address, fetch_pc;
  logic        wake_disable, serial_line_unit_break, start_valid, bus_power_ok, irq;
  logic        backplane_power_ok, bus_timeout_error, interrupt_acknowledge_cycle;
  logic        bus_halt_line_in, timeout_nmi_request, halt_irq_request, bus_halt_line;
  logic        bus_event_line;
  logic [2:0]  halt_irq_priority;
  logic [8:0]  halt_irq_vector;
  int          error_cnt, n_tests, nmi_cnt, halt_cnt;
  int          up_cyc, ev_wait;
  startup_config #(.WAKE_CYCLES(WAKE)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .start_strap, .wake_disable,
    .backplane_power_ok, .bus_timeout_error, .interrupt_acknowledge_cycle,
    .serial_line_unit_break, .bus_halt_line_in, .start_address, .restart_address,
    .start_valid, .bus_power_ok, .timeout_nmi_request, .halt_irq_request,
    .halt_irq_priority, .halt_irq_vector, .bus_halt_line, .bus_event_line, .irq);
  bus_partner partner_u (.pclk, .presetn, .start_address, .start_valid,
    .timeout_nmi_request, .halt_irq_request, .bus_halt_line, .backplane_power_ok,
    .bus_timeout_error, .interrupt_acknowledge_cycle, .bus_halt_line_in, .fetch_pc,
    .nmi_cnt, .halt_cnt);
  ////////////////////////////////////////
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic do_reset();
    presetn <= 1'b0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
  endtask : do_reset
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    // no cycle count assumed: only the hang guard ends this wait
    do begin
      tick(1);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    check("pready", 32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // cycles since the last reset release, to time the clock event
  always @(posedge pclk) begin
    up_cyc <= presetn ? up_cyc + 1 : 0;
  end
  // hang guard: the 800 Hz wait alone takes over 62,000 cycles
  initial begin
    tick(70000);
    error_cnt++;
    close_out();
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, serial_line_unit_break, wake_disable} = '0;
    paddr = '0;
    pwdata = '0;
    start_strap = 3'h4;
    for (int s = 0; s < 8; s++) begin
      start_strap <= 3'(s);
      do_reset();
      @(negedge pclk);
      check("start", 32'(start_address), 32'(START_MAP[s]));
      check("restart", 32'(restart_address), 32'(START_MAP[s] + 16'h0004));
      check("valid", 32'(start_valid), 32'h1);
      check("power", 32'(bus_power_ok), 32'h0);
      tick(1);
      start_strap <= ~3'(s);
      apb(1'b0, 12'h00C, 32'h0);
      check("start_reg", rd_q, 32'(START_MAP[s]));
      apb(1'b0, 12'h010, 32'h0);
      check("restart_reg", rd_q, 32'(START_MAP[s] + 16'h0004));
      check("fetch", 32'(fetch_pc), 32'(START_MAP[s]));
    end
    tick(WAKE);
    check("power_up", 32'(bus_power_ok), 32'h1);
    wake_disable <= 1'b1;
    do_reset();
    tick(2);
    check("bypass_lo", 32'(bus_power_ok), 32'h0);
    partner_u.power(1'b1);
    tick(3);
    check("bypass_hi", 32'(bus_power_ok), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check("config", rd_q, 32'h1F);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", rd_q, 32'h0);
    check("slverr", 32'(err_q), 32'h1);
    apb(1'b1, 12'h00C, 32'hFFFF);
    apb(1'b0, 12'h00C, 32'h0);
    check("start_ro", rd_q, 32'(START_MAP[0]));
    partner_u.pulse(1'b0, 1'b1, 3);
    check("nmi_iak", 32'(nmi_cnt), 32'h0);
    partner_u.pulse(1'b0, 1'b0, 3);
    check("nmi", 32'(nmi_cnt), 32'h1);
    partner_u.pulse(1'b1, 1'b0, 1);
    check("halt", 32'(halt_cnt), 32'h1);
    check("prio", 32'(halt_irq_priority), 32'h7);
    check("vector", 32'(halt_irq_vector), 32'h60);
    serial_line_unit_break <= 1'b1;
    tick(2);
    check("halt_line", 32'(bus_halt_line), 32'h1);
    serial_line_unit_break <= 1'b0;
    tick(3);
    check("halt_loop", 32'(halt_cnt), 32'h2);
    check("irq_masked", 32'(irq), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("status", rd_q, 32'h3);
    apb(1'b1, 12'h004, 32'h3);
    tick(2);
    check("irq_on", 32'(irq), 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    tick(2);
    check("irq_halt", 32'(irq), 32'h1);
    apb(1'b1, 12'h000, 32'h2);
    tick(2);
    check("irq_clear", 32'(irq), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("status_clr", rd_q, 32'h0);
    apb(1'b1, 12'h008, 32'h2F);
    apb(1'b0, 12'h008, 32'h0);
    check("rtc_800", rd_q, 32'h2F);
    // only the 800 Hz wave has a half period short enough for the run
    ev_wait = 0;
    while (bus_event_line !== 1'b1 && ev_wait < 63000) begin
      tick(1);
      ev_wait++;
    end
    check("event_rise", 32'(bus_event_line), 32'h1);
    check("event_time", 32'(up_cyc), 32'(`RTC800_CYCLES / 2 + 1));
    apb(1'b0, 12'h000, 32'h0);
    check("status_rtc", rd_q, 32'h4);
    check("irq_rtc_off", 32'(irq), 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check("rtc_waves", rd_q, 32'h4);
    apb(1'b1, 12'h008, 32'h3F);
    apb(1'b0, 12'h008, 32'h0);
    check("rtc_sel", rd_q, 32'h3F);
    tick(2);
    check("event_off", 32'(bus_event_line), 32'h0);
    close_out();
  end
endmodule : test_startup_config
